// ===== rtl/dbp_defines.svh
/*
  Constants for the host that drives the double-buffered converter input port.
  Assumes a 100 MHz system clock; included by bare name from the rtl files.
*/
// Operation
// - All control pins are active low
// - Chip select low for every latch access; the wide variant holds cs_n high instead; here a wide OP_BYTE_HI still drives cs_n low
// - Serial bits MSB first, one per write
// - Latch strobe rate at most 10MHz
// - At least 20ns between successive-enable writes
// - Serial shift rate at most 10MHz
`ifndef DBP_DEFINES_SVH
`define DBP_DEFINES_SVH

// Timing in ns
`define DBP_CLK_NS 10
`define DBP_MAX_RATE_NS 100
`define DBP_GAP_NS 20

// Derived cycle counts, least times rounded up
`define DBP_WR_LOW_CYC (((`DBP_MAX_RATE_NS / 2) + `DBP_CLK_NS - 1) / `DBP_CLK_NS)
`define DBP_WR_HIGH_CYC (((`DBP_MAX_RATE_NS / 2) + `DBP_CLK_NS - 1) / `DBP_CLK_NS)
`define DBP_HOLD_CYC ((`DBP_GAP_NS + `DBP_CLK_NS - 1) / `DBP_CLK_NS)
`define DBP_SETUP_CYC (`DBP_WR_HIGH_CYC - `DBP_HOLD_CYC)

// Widths and counts
`define DBP_CNT_W 4
`define DBP_WORD_W 16
`define DBP_BYTE_W 8
`define DBP_SER_LAST 5'h0f
`define DBP_SER_BITS 5'h10
`define DBP_BIT_MSB 4'hf
`define DBP_CLEAR_CODE 16'h0000

`endif

// ===== rtl/dbp_pkg.sv
/*
  Types for the converter port host.
  Assumes nothing beyond the defines header.
*/
package dbp_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_BUSY = 2'h1
  } dbp_state_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_SETUP = 2'h1,
    PH_LOW = 2'h3,
    PH_HOLD = 2'h2
  } dbp_phase_t;

  typedef enum logic [2:0] {
    OP_BYTE_LO = 3'h0,
    OP_BYTE_HI = 3'h1,
    OP_XFER = 3'h2,
    OP_WORD = 3'h3,
    OP_SERIAL = 3'h4,
    OP_CLEAR = 3'h5
  } dbp_op_t;

  typedef enum logic [2:0] {
    K_END = 3'h0,
    K_LO = 3'h1,
    K_HI = 3'h2,
    K_SER = 3'h3,
    K_XFER = 3'h4,
    K_CLR = 3'h5
  } dbp_kind_t;

  typedef struct packed {
    logic cs_n;
    logic lo_n;
    logic hi_n;
    logic xf_n;
    logic [15:0] data;
  } dbp_pins_t;

endpackage

// ===== rtl/dbp_strobe_if.sv
/*
  Link between the host sequencer and its write/clear strobe timer.
  Assumes both ends on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
interface dbp_strobe_if;
  logic go;
  logic use_clr;
  logic done;
  logic wr_n;
  logic clr_n;
  modport ctrl (output go, output use_clr, input done, input wr_n, input clr_n);
  modport gen (input go, input use_clr, output done, output wr_n, output clr_n);
endinterface
`default_nettype wire

// ===== rtl/dbp_strobe.sv
/*
  Strobe timer: setup, low pulse and hold for one write or clear.
  Assumes pins are set by the sequencer in the cycle go is raised.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dbp_defines.svh"
module dbp_strobe (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Sequencer side
  dbp_strobe_if.gen sb
);

  dbp_pkg::dbp_phase_t ph_r;
  logic [`DBP_CNT_W-1:0] cnt_r;
  logic clr_sel_r;

  ////////////////////////////////////////////////////////////////////////
  // Phase timer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ph_r <= dbp_pkg::PH_IDLE;
      cnt_r <= '0;
      clr_sel_r <= 1'b0;
    end else begin
      case (ph_r)
        dbp_pkg::PH_IDLE: begin
          if (sb.go) begin
            ph_r <= dbp_pkg::PH_SETUP;
            cnt_r <= `DBP_CNT_W'(`DBP_SETUP_CYC - 1);
            clr_sel_r <= sb.use_clr;
          end
        end
        dbp_pkg::PH_SETUP: begin
          if (cnt_r == '0) begin
            ph_r <= dbp_pkg::PH_LOW;
            cnt_r <= `DBP_CNT_W'(`DBP_WR_LOW_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        dbp_pkg::PH_LOW: begin
          if (cnt_r == '0) begin
            ph_r <= dbp_pkg::PH_HOLD;
            cnt_r <= `DBP_CNT_W'(`DBP_HOLD_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        dbp_pkg::PH_HOLD: begin
          if (cnt_r == '0) begin
            ph_r <= dbp_pkg::PH_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: ph_r <= dbp_pkg::PH_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Strobe pins and done pulse
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sb.wr_n <= 1'b1;
      sb.clr_n <= 1'b1;
      sb.done <= 1'b0;
    end else begin
      sb.wr_n <= !((ph_r == dbp_pkg::PH_SETUP && cnt_r == '0 && !clr_sel_r) ||
                   (ph_r == dbp_pkg::PH_LOW && cnt_r != '0 && !clr_sel_r));
      sb.clr_n <= !((ph_r == dbp_pkg::PH_SETUP && cnt_r == '0 && clr_sel_r) ||
                    (ph_r == dbp_pkg::PH_LOW && cnt_r != '0 && clr_sel_r));
      sb.done <= (ph_r == dbp_pkg::PH_HOLD && cnt_r == '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_wr_low_width: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(sb.wr_n) |=> !sb.wr_n [*4] ##1 sb.wr_n)
    else $error("write pulse width wrong");
  a_wr_high_gap: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(sb.wr_n) |-> sb.wr_n [*5])
    else $error("write high time too short");
  a_clr_no_wr: assert property (@(posedge clk_sys) disable iff (!rstn)
    !sb.clr_n |-> sb.wr_n)
    else $error("clear overlaps write");

endmodule // dbp_strobe
`default_nettype wire

// ===== rtl/dbp_host.sv
/*
  Host sequencer driving the converter's latch enables, write, clear and data.
  Assumes command inputs come from logic on clk_sys; pins go to the device.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dbp_defines.svh"
module dbp_host (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Command side
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [15:0] cmd_data,
  input wire logic cmd_wide,
  output logic cmd_ready,
  output logic cmd_done,
  output logic cmd_err,
  // Device pins
  output logic cs_n,
  output logic wr_n,
  output logic low_byte_enable_n,
  output logic high_byte_enable_n,
  output logic transfer_enable_n,
  output logic clear_n,
  output logic [15:0] dac_data
);

  dbp_strobe_if sif ();

  dbp_pkg::dbp_state_t state_r, state_nxt;
  dbp_pkg::dbp_kind_t kind_r, kind_nxt;
  dbp_pkg::dbp_op_t op_r, op_nxt;
  dbp_pkg::dbp_pins_t pins_r;
  logic [15:0] word_r, word_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic [4:0] bitcnt_r, bitcnt_nxt;
  logic wide_r, wide_nxt;
  logic go_nxt, done_nxt, err_nxt;
  logic ready_r, done_r, err_r, go_r, clr_r;

  ////////////////////////////////////////////////////////////////////////
  // Step decode
  function automatic dbp_pkg::dbp_kind_t first_kind(input dbp_pkg::dbp_op_t op);
    case (op)
      dbp_pkg::OP_BYTE_LO: first_kind = dbp_pkg::K_LO;
      dbp_pkg::OP_BYTE_HI: first_kind = dbp_pkg::K_HI;
      dbp_pkg::OP_XFER: first_kind = dbp_pkg::K_XFER;
      dbp_pkg::OP_WORD: first_kind = dbp_pkg::K_LO;
      dbp_pkg::OP_SERIAL: first_kind = dbp_pkg::K_SER;
      dbp_pkg::OP_CLEAR: first_kind = dbp_pkg::K_CLR;
      default: first_kind = dbp_pkg::K_END;
    endcase
  endfunction

  function automatic dbp_pkg::dbp_kind_t next_kind(input dbp_pkg::dbp_kind_t k, input dbp_pkg::dbp_op_t op,
                                                   input logic wide, input logic [4:0] cnt);
    next_kind = dbp_pkg::K_END;
    case (k)
      dbp_pkg::K_LO: begin
        if (op == dbp_pkg::OP_WORD) begin
          next_kind = wide ? dbp_pkg::K_XFER : dbp_pkg::K_HI;
        end
      end
      dbp_pkg::K_HI: begin
        if (op == dbp_pkg::OP_WORD) begin
          next_kind = dbp_pkg::K_XFER;
        end
      end
      dbp_pkg::K_SER: begin
        next_kind = (cnt == `DBP_SER_LAST) ? dbp_pkg::K_XFER : dbp_pkg::K_SER;
      end
      default: next_kind = dbp_pkg::K_END;
    endcase
  endfunction

  // Pin levels for one step; enables idle high
  function automatic dbp_pkg::dbp_pins_t pin_map(input dbp_pkg::dbp_kind_t k, input logic wide,
                                                 input logic [15:0] w, input logic [15:0] s);
    pin_map = '{cs_n: 1'b1, lo_n: 1'b1, hi_n: 1'b1, xf_n: 1'b1, data: '0};
    case (k)
      dbp_pkg::K_LO: begin
        pin_map.cs_n = wide;
        pin_map.lo_n = 1'b0;
        pin_map.data = wide ? w : {8'h00, w[`DBP_BYTE_W-1:0]};
      end
      dbp_pkg::K_HI: begin
        pin_map.cs_n = 1'b0;
        pin_map.hi_n = 1'b0;
        pin_map.data = {8'h00, w[`DBP_WORD_W-1:`DBP_BYTE_W]};
      end
      dbp_pkg::K_SER: begin
        pin_map.cs_n = 1'b0;
        pin_map.lo_n = 1'b0;
        pin_map.hi_n = 1'b0;
        pin_map.data = {15'h0000, s[`DBP_WORD_W-1]};
      end
      dbp_pkg::K_XFER: begin
        pin_map.cs_n = wide;
        pin_map.hi_n = !wide;
        pin_map.xf_n = wide;
      end
      default: pin_map.cs_n = 1'b1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    op_nxt = op_r;
    word_nxt = word_r;
    shift_nxt = shift_r;
    bitcnt_nxt = bitcnt_r;
    wide_nxt = wide_r;
    go_nxt = 1'b0;
    done_nxt = 1'b0;
    err_nxt = 1'b0;
    case (state_r)
      dbp_pkg::ST_IDLE: begin
        if (cmd_valid) begin
          if ((cmd_op == dbp_pkg::OP_SERIAL && cmd_wide) || cmd_op > dbp_pkg::OP_CLEAR) begin
            err_nxt = 1'b1;
          end else begin
            op_nxt = dbp_pkg::dbp_op_t'(cmd_op);
            kind_nxt = first_kind(dbp_pkg::dbp_op_t'(cmd_op));
            word_nxt = cmd_data;
            shift_nxt = cmd_data;
            bitcnt_nxt = '0;
            wide_nxt = cmd_wide;
            go_nxt = 1'b1;
            state_nxt = dbp_pkg::ST_BUSY;
          end
        end
      end
      dbp_pkg::ST_BUSY: begin
        if (sif.done) begin
          if (kind_r == dbp_pkg::K_SER) begin
            shift_nxt = {shift_r[`DBP_WORD_W-2:0], 1'b0};
            bitcnt_nxt = bitcnt_r + 5'h01;
          end
          kind_nxt = next_kind(kind_r, op_r, wide_r, bitcnt_r);
          if (kind_nxt == dbp_pkg::K_END) begin
            state_nxt = dbp_pkg::ST_IDLE;
            done_nxt = 1'b1;
          end else begin
            go_nxt = 1'b1;
          end
        end
      end
      default: state_nxt = dbp_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= dbp_pkg::ST_IDLE;
      kind_r <= dbp_pkg::K_END;
      op_r <= dbp_pkg::OP_BYTE_LO;
      word_r <= `DBP_CLEAR_CODE;
      shift_r <= `DBP_CLEAR_CODE;
      bitcnt_r <= '0;
      wide_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      op_r <= op_nxt;
      word_r <= word_nxt;
      shift_r <= shift_nxt;
      bitcnt_r <= bitcnt_nxt;
      wide_r <= wide_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins and command status
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pins_r <= '{cs_n: 1'b1, lo_n: 1'b1, hi_n: 1'b1, xf_n: 1'b1, data: '0};
      ready_r <= 1'b1;
      done_r <= 1'b0;
      err_r <= 1'b0;
      go_r <= 1'b0;
      clr_r <= 1'b0;
    end else begin
      if (state_r == dbp_pkg::ST_IDLE || sif.done) begin
        pins_r <= pin_map(kind_nxt, wide_nxt, word_nxt, shift_nxt);
      end
      ready_r <= (state_nxt == dbp_pkg::ST_IDLE);
      done_r <= done_nxt;
      err_r <= err_nxt;
      go_r <= go_nxt;
      clr_r <= (kind_nxt == dbp_pkg::K_CLR);
    end
  end

  assign sif.go = go_r;
  assign sif.use_clr = clr_r;

  dbp_strobe u_strobe (
    .clk_sys (clk_sys),
    .rstn (rstn),
    .sb (sif.gen)
  );

  assign cmd_ready = ready_r;
  assign cmd_done = done_r;
  assign cmd_err = err_r;
  assign cs_n = pins_r.cs_n;
  assign low_byte_enable_n = pins_r.lo_n;
  assign high_byte_enable_n = pins_r.hi_n;
  assign transfer_enable_n = pins_r.xf_n;
  assign dac_data = pins_r.data;
  assign wr_n = sif.wr_n;
  assign clear_n = sif.clr_n;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_cs_on_write: assert property ($fell(wr_n) && !wide_r |-> !cs_n)
    else $error("write without chip select");
  a_byte_lo_data: assert property ($fell(wr_n) && !low_byte_enable_n && high_byte_enable_n && !wide_r
    |-> dac_data == {8'h00, word_r[7:0]})
    else $error("low byte data wrong");
  a_xfer_alone: assert property (!transfer_enable_n |-> low_byte_enable_n && high_byte_enable_n)
    else $error("transfer overlaps byte enable");
  a_pins_stable: assert property (!wr_n |-> $stable({cs_n, low_byte_enable_n, high_byte_enable_n,
    transfer_enable_n, dac_data}))
    else $error("pins moved during write");
  a_serial_msb: assert property ($fell(wr_n) && !low_byte_enable_n && !high_byte_enable_n
    |-> dac_data[0] == word_r[`DBP_BIT_MSB - bitcnt_r[3:0]])
    else $error("serial bit order wrong");
  a_serial_count: assert property (kind_r == dbp_pkg::K_XFER && $past(kind_r) == dbp_pkg::K_SER
    |-> bitcnt_r == `DBP_SER_BITS)
    else $error("serial transfer before sixteen bits");
  a_wide_word: assert property ($fell(wr_n) && wide_r && !low_byte_enable_n |-> dac_data == word_r)
    else $error("wide word data wrong");
  a_wide_pins: assert property (wide_r && state_r == dbp_pkg::ST_BUSY |-> cs_n && transfer_enable_n)
    else $error("wide variant drove chip select");

endmodule // dbp_host
`default_nettype wire

// ===== testbench/dbp_dev_model.sv
/*
  Behavioural model of the converter input port: byte latches, serial shift,
  converter latch, clear, and a strobe timing watch.
  Assumes pins come straight from the host; no clock, strobes act on edges.
*/
`timescale 1ns/10ps
`default_nettype none
module dbp_dev_model (
  // Variant select
  input wire logic wide,
  // Control pins
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic low_byte_enable_n,
  input wire logic high_byte_enable_n,
  input wire logic transfer_enable_n,
  input wire logic clear_n,
  // Data pins
  input wire logic [15:0] data,
  // Observation
  output logic [15:0] conv,
  output int n_bad
);
  logic [7:0] lo_r;
  logic [7:0] hi_r;
  logic [15:0] word_r;
  realtime t_fall;
  realtime t_rise;

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    n_bad = 0;
    t_fall = -1000.0;
    t_rise = -1000.0;
    lo_r = 'x;
    hi_r = 'x;
    word_r = 'x;
    conv = 'x;
  end

  // Capture on falling write
  always @(negedge wr_n) begin
    if ($realtime - t_fall < 100.0) n_bad++;
    if ($realtime - t_rise < 20.0) n_bad++;
    t_fall = $realtime;
    if (wide) begin
      if (!low_byte_enable_n) word_r = data;
      if (!high_byte_enable_n) conv = word_r;
    end else if (!cs_n) begin
      if (!low_byte_enable_n && !high_byte_enable_n) begin
        {hi_r, lo_r} = {hi_r[6:0], lo_r, data[0]};
      end else begin
        if (!low_byte_enable_n) lo_r = data[7:0];
        if (!high_byte_enable_n) hi_r = data[7:0];
      end
      if (!transfer_enable_n) conv = {hi_r, lo_r};
    end
  end

  always @(posedge wr_n) t_rise = $realtime;

  // Clear zeroes everything
  always @(negedge clear_n) begin
    lo_r = 8'h00;
    hi_r = 8'h00;
    word_r = 16'h0000;
    conv = 16'h0000;
  end
endmodule // dbp_dev_model
`default_nettype wire

// ===== testbench/test_dac_double_buffered_input_port.sv
/*
  Self-checking bench for the converter port host.
  Assumes the device model beside it; commands driven 1 ns after clock edges.
*/
`timescale 1ns/10ps
`default_nettype none
module test_dac_double_buffered_input_port;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [15:0] cmd_data = 16'h0000;
  logic cmd_wide = 1'b0;
  logic cmd_ready, cmd_done, cmd_err, cs_n, wr_n, lo_n, hi_n, xf_n, clr_n;
  logic [15:0] dac_data;
  logic [15:0] conv;
  int n_bad;
  int n_fail = 0;
  int cmp_count = 0;

  always #5 clk_sys = ~clk_sys;

  dbp_host dbp_host_i (.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .cmd_wide(cmd_wide), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
    .cmd_err(cmd_err), .cs_n(cs_n), .wr_n(wr_n), .low_byte_enable_n(lo_n), .high_byte_enable_n(hi_n),
    .transfer_enable_n(xf_n), .clear_n(clr_n), .dac_data(dac_data));

  dbp_dev_model dbp_dev_model_i (.wide(cmd_wide), .cs_n(cs_n), .wr_n(wr_n), .low_byte_enable_n(lo_n),
    .high_byte_enable_n(hi_n), .transfer_enable_n(xf_n), .clear_n(clr_n), .data(dac_data),
    .conv(conv), .n_bad(n_bad));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic stop_test;
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One command, bounded wait for done or refusal
  task automatic run_cmd(input logic [2:0] op, input logic [15:0] d, input logic w, input logic exp_err);
    int i;
    i = 0;
    chk("cmd_ready", 16'h0001, {15'h0000, cmd_ready});
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_wide = w;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
    while (cmd_done !== 1'b1 && cmd_err !== 1'b1) begin
      if (i == 400) begin
        n_fail++;
        stop_test();
      end
      i++;
      @(posedge clk_sys);
      #1;
    end
    chk("cmd_err", {15'h0000, exp_err}, {15'h0000, cmd_err});
    @(posedge clk_sys);
    #1;
  endtask

  task automatic idle_pins;
    chk("idle pins", 16'h003f, {10'h000, cs_n, wr_n, lo_n, hi_n, xf_n, clr_n});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_clear;
    run_cmd(3'h5, 16'h0000, 1'b0, 1'b0);
    chk("conv clear", 16'h0000, conv);
    chk("unipolar clear", 16'h8000, conv ^ 16'h8000);
    idle_pins();
  endtask

  task automatic t_bytes;
    run_cmd(3'h0, 16'h1234, 1'b0, 1'b0);
    run_cmd(3'h1, 16'h5678, 1'b0, 1'b0);
    chk("conv before xfer", 16'h0000, conv);
    run_cmd(3'h2, 16'h0000, 1'b0, 1'b0);
    chk("conv bytes", 16'h5634, conv);
  endtask

  task automatic t_words;
    logic [15:0] v[3];
    v = '{16'h7fff, 16'h8000, 16'hffff};
    foreach (v[k]) begin
      run_cmd(3'h3, v[k], 1'b0, 1'b0);
      chk("conv word", v[k], conv);
    end
  endtask

  task automatic t_serial;
    run_cmd(3'h4, 16'ha5c3, 1'b0, 1'b0);
    chk("conv serial", 16'ha5c3, conv);
    run_cmd(3'h4, 16'h0001, 1'b0, 1'b0);
    chk("conv serial lsb", 16'h0001, conv);
  endtask

  task automatic t_wide;
    run_cmd(3'h3, 16'h1357, 1'b1, 1'b0);
    chk("conv wide", 16'h1357, conv);
    chk("cs wide", 16'h0001, {15'h0000, cs_n});
  endtask

  task automatic t_refuse;
    run_cmd(3'h4, 16'hffff, 1'b1, 1'b1);
    run_cmd(3'h6, 16'hffff, 1'b0, 1'b1);
    run_cmd(3'h7, 16'hffff, 1'b0, 1'b1);
    chk("conv kept", 16'h1357, conv);
    idle_pins();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    idle_pins();
    chk("data reset", 16'h0000, dac_data);
    t_clear();
    t_bytes();
    t_words();
    t_serial();
    t_wide();
    t_refuse();
    chk("strobe timing", 16'h0000, n_bad[15:0]);
    stop_test();
  end
endmodule // test_dac_double_buffered_input_port
`default_nettype wire
